// File: ebls_map.svh
`ifndef EBLS_MAP_SVH
`define EBLS_MAP_SVH
// ======================================================
// widths and lane positions
`define EBLS_ADDR_W 32
`define EBLS_DATA_W 48
`define EBLS_BANKS 4
`define EBLS_LANE_W32_LSB 16
`define EBLS_LANE_W40_LSB 8
`define EBLS_LANE_W16_LSB 16
`define EBLS_LANE_W8_LSB 16
// ======================================================
// default bank size field: log2 of words per bank
`define EBLS_BANK_LOG2_RST 5'h18
// ======================================================
// access cycles before the filtered acknowledge can be trusted
`define EBLS_ACK_SETTLE 3'h4
// ======================================================
// reset values
`define EBLS_BANK_SEL_IDLE 4'hF
`define EBLS_ZERO_ADDR 32'h0000_0000
`define EBLS_ZERO_DATA 48'h0000_0000_0000
`endif

// File: ebls_pkg.sv
package ebls_pkg;
   typedef enum logic [1:0] {
      EBLS_W32,
      EBLS_W40,
      EBLS_W16,
      EBLS_W8
   } ebls_width_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic cond;
      ebls_width_t width;
      logic [31:0] addr;
      logic [39:0] wdata;
   } ebls_req_t;

   typedef struct packed {
      logic done;
      logic [39:0] rdata;
   } ebls_rsp_t;
endpackage

// File: ebls_lane_select.sv
`timescale 1ns/100ps
`include "ebls_map.svh"
// How it works
// - as bus master the block drives the full 32-bit address for external accesses.
// - when another master or host accesses internal memory, the address pins are taken as inputs.
// - 32-bit float and fixed words use data bits 47 to 16.
// - 40-bit extended words use data bits 47 to 8.
// - 16-bit short words use data bits 31 to 16.
// - byte-wide PROM boot data uses data bits 23 to 16.
// - four active-low bank selects, sized from the system config register.
// - bank selects are decoded from the address and change with the address.
// - selects stay idle with no external access, but a conditional access asserts the bank anyway.
// - bank zero select together with the page signal can select a DRAM bank.
// - only the bus master drives the bank select lines.
// - bus outputs float while bus suspend is asserted or the block is a slave.
// - synchronous inputs are sampled on the clock, asynchronous ones are synchronised first.
// - data inputs keep their last driven level when undriven; address inputs are taken every cycle the block does not drive them.
module ebls_lane_select
   import ebls_pkg::*;
#(
   parameter int ADDR_W = `EBLS_ADDR_W,
   parameter int DATA_W = `EBLS_DATA_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // core side
   input wire ebls_req_t core_req,
   output ebls_rsp_t core_rsp,
   input wire logic [4:0] system_config_register,
   input wire logic bus_master,
   input wire logic page_cross,
   // slave side address capture
   output logic [ADDR_W-1:0] slave_addr,
   // external address pins
   input wire logic [ADDR_W-1:0] addr_in,
   output logic [ADDR_W-1:0] addr_out,
   output logic addr_oe_n,
   // external data pins
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] data_in_en,
   output logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_oe_n,
   // bank selects and dram page
   output logic [3:0] bank_select_n,
   output logic bank_select_oe_n,
   output logic dram_sel_n,
   output logic page_out,
   // control pins
   input wire logic bus_suspend_tristate,
   input wire logic ack_in
);
   // ======================================================
   // input synchronisers
   logic [2:0] bus_suspend_tristate_sync_ff, nxt_bus_suspend_tristate_sync;
   logic bus_suspend_tristate_q_ff, nxt_bus_suspend_tristate_q;
   logic [2:0] ack_sync_ff, nxt_ack_sync;
   logic ack_q_ff, nxt_ack_q;

   always_comb begin
      nxt_bus_suspend_tristate_sync = {bus_suspend_tristate_sync_ff[1:0], bus_suspend_tristate};
      nxt_ack_sync = {ack_sync_ff[1:0], ack_in};
      nxt_bus_suspend_tristate_q = bus_suspend_tristate_q_ff;
      nxt_ack_q = ack_q_ff;
      if (bus_suspend_tristate_sync_ff[1] == bus_suspend_tristate_sync_ff[2]) begin
         nxt_bus_suspend_tristate_q = bus_suspend_tristate_sync_ff[2];
      end
      if (ack_sync_ff[1] == ack_sync_ff[2]) begin
         nxt_ack_q = ack_sync_ff[2];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_suspend_tristate_sync_ff <= 3'h0;
         bus_suspend_tristate_q_ff <= 1'b0;
         ack_sync_ff <= 3'h7;
         ack_q_ff <= 1'b1;
      end else begin
         bus_suspend_tristate_sync_ff <= nxt_bus_suspend_tristate_sync;
         bus_suspend_tristate_q_ff <= nxt_bus_suspend_tristate_q;
         ack_sync_ff <= nxt_ack_sync;
         ack_q_ff <= nxt_ack_q;
      end
   end

   // ======================================================
   // functions
   function automatic logic [3:0] bank_decode(input logic [31:0] a, input logic [4:0] log2sz);
      logic [31:0] idx;
      idx = a >> log2sz;
      bank_decode = 4'hF;
      if (idx < 32'h4) begin
         bank_decode[idx[1:0]] = 1'b0;
      end
   endfunction

   function automatic logic [47:0] lane_mask(input ebls_width_t w);
      case (w)
         EBLS_W32: lane_mask = 48'hFFFF_FFFF_0000;
         EBLS_W40: lane_mask = 48'hFFFF_FFFF_FF00;
         EBLS_W16: lane_mask = 48'h0000_FFFF_0000;
         EBLS_W8: lane_mask = 48'h0000_00FF_0000;
         default: lane_mask = 48'h0000_0000_0000;
      endcase
   endfunction

   function automatic logic [47:0] lane_place(input ebls_width_t w, input logic [39:0] d);
      case (w)
         EBLS_W32: lane_place = {d[31:0], 16'h0000};
         EBLS_W40: lane_place = {d, 8'h00};
         EBLS_W16: lane_place = {16'h0000, d[15:0], 16'h0000};
         EBLS_W8: lane_place = {24'h000000, d[7:0], 16'h0000};
         default: lane_place = 48'h0000_0000_0000;
      endcase
   endfunction

   function automatic logic [39:0] lane_take(input ebls_width_t w, input logic [47:0] d);
      case (w)
         EBLS_W32: lane_take = {8'h00, d[47:16]};
         EBLS_W40: lane_take = d[47:8];
         EBLS_W16: lane_take = {24'h000000, d[31:16]};
         EBLS_W8: lane_take = {32'h0000_0000, d[23:16]};
         default: lane_take = 40'h00_0000_0000;
      endcase
   endfunction

   // ======================================================
   // pin hold latches on address and data inputs
   logic [ADDR_W-1:0] addr_hold_ff, nxt_addr_hold;
   logic [DATA_W-1:0] data_hold_ff, nxt_data_hold;
   logic [ADDR_W-1:0] addr_sync_ff, nxt_addr_sync;

   always_comb begin
      nxt_addr_hold = addr_hold_ff;
      if (!addr_oe_n == 1'b0) begin
         nxt_addr_hold = addr_in;
      end
      nxt_addr_sync = addr_hold_ff;
   end

   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_hold
         always_comb begin
            nxt_data_hold[gi] = data_in_en[gi] ? data_in[gi] : data_hold_ff[gi];
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_hold_ff <= `EBLS_ZERO_ADDR;
         addr_sync_ff <= `EBLS_ZERO_ADDR;
         data_hold_ff <= `EBLS_ZERO_DATA;
      end else begin
         addr_hold_ff <= nxt_addr_hold;
         addr_sync_ff <= nxt_addr_sync;
         data_hold_ff <= nxt_data_hold;
      end
   end

   // ======================================================
   // access sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_DONE
   } ebls_state_t;

   ebls_state_t state_ff, nxt_state;
   ebls_req_t cur_ff, nxt_cur;
   ebls_rsp_t rsp_ff, nxt_rsp;
   logic [ADDR_W-1:0] addr_out_ff, nxt_addr_out;
   logic [DATA_W-1:0] data_out_ff, nxt_data_out;
   logic [DATA_W-1:0] data_oe_n_ff, nxt_data_oe_n;
   logic addr_oe_n_ff, nxt_addr_oe_n;
   logic [3:0] bsel_ff, nxt_bsel;
   logic bsel_oe_n_ff, nxt_bsel_oe_n;
   logic dram_ff, nxt_dram;
   logic page_ff, nxt_page;
   logic [2:0] acc_cnt_ff, nxt_acc_cnt;
   logic drive_ok;

   always_comb begin
      drive_ok = bus_master && !bus_suspend_tristate_q_ff;
      nxt_state = state_ff;
      nxt_cur = cur_ff;
      nxt_rsp = rsp_ff;
      nxt_rsp.done = 1'b0;
      nxt_addr_out = addr_out_ff;
      nxt_data_out = data_out_ff;
      nxt_data_oe_n = {DATA_W{1'b1}};
      nxt_bsel = `EBLS_BANK_SEL_IDLE;
      nxt_dram = 1'b1;
      nxt_page = 1'b0;
      nxt_acc_cnt = 3'h0;
      case (state_ff)
         ST_IDLE: begin
            if (core_req.valid && drive_ok) begin
               nxt_cur = core_req;
               nxt_state = ST_ACCESS;
               nxt_addr_out = core_req.addr;
               nxt_bsel = bank_decode(core_req.addr, system_config_register);
            end
         end
         ST_ACCESS: begin
            nxt_bsel = bank_decode(cur_ff.addr, system_config_register);
            // a stale high acknowledge must not end the access before a wait shows through the filter
            nxt_acc_cnt = (acc_cnt_ff == 3'h7) ? acc_cnt_ff : acc_cnt_ff + 3'h1;
            nxt_dram = nxt_bsel[0] | ~page_cross;
            nxt_page = page_cross & ~nxt_bsel[0];
            if (cur_ff.write && cur_ff.cond) begin
               nxt_data_out = lane_place(cur_ff.width, cur_ff.wdata);
               nxt_data_oe_n = ~lane_mask(cur_ff.width);
            end
            if (!drive_ok) begin
               nxt_state = ST_IDLE;
               nxt_bsel = `EBLS_BANK_SEL_IDLE;
            end else if (ack_q_ff && acc_cnt_ff >= `EBLS_ACK_SETTLE) begin
               nxt_state = ST_DONE;
               nxt_rsp.done = 1'b1;
               nxt_bsel = `EBLS_BANK_SEL_IDLE;
               nxt_dram = 1'b1;
               nxt_page = 1'b0;
               nxt_rsp.rdata = cur_ff.write ? 40'h00_0000_0000
                  : lane_take(cur_ff.width, data_hold_ff & lane_mask(cur_ff.width));
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      nxt_addr_oe_n = !drive_ok;
      nxt_bsel_oe_n = !drive_ok;
      if (!drive_ok) begin
         nxt_data_oe_n = {DATA_W{1'b1}};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         cur_ff <= '0;
         rsp_ff <= '0;
         addr_out_ff <= `EBLS_ZERO_ADDR;
         data_out_ff <= `EBLS_ZERO_DATA;
         data_oe_n_ff <= {DATA_W{1'b1}};
         addr_oe_n_ff <= 1'b1;
         bsel_ff <= `EBLS_BANK_SEL_IDLE;
         bsel_oe_n_ff <= 1'b1;
         dram_ff <= 1'b1;
         page_ff <= 1'b0;
         acc_cnt_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         cur_ff <= nxt_cur;
         rsp_ff <= nxt_rsp;
         addr_out_ff <= nxt_addr_out;
         data_out_ff <= nxt_data_out;
         data_oe_n_ff <= nxt_data_oe_n;
         addr_oe_n_ff <= nxt_addr_oe_n;
         bsel_ff <= nxt_bsel;
         bsel_oe_n_ff <= nxt_bsel_oe_n;
         dram_ff <= nxt_dram;
         page_ff <= nxt_page;
         acc_cnt_ff <= nxt_acc_cnt;
      end
   end

   assign core_rsp = rsp_ff;
   assign addr_out = addr_out_ff;
   assign addr_oe_n = addr_oe_n_ff;
   assign data_out = data_out_ff;
   assign data_oe_n = data_oe_n_ff;
   assign bank_select_n = bsel_ff;
   assign bank_select_oe_n = bsel_oe_n_ff;
   assign dram_sel_n = dram_ff;
   assign page_out = page_ff;
   assign slave_addr = addr_sync_ff;
endmodule

// File: ebls_lane_chk.sv
`timescale 1ns/100ps
module ebls_lane_chk
   import ebls_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // core side
   input wire ebls_req_t core_req,
   input wire ebls_rsp_t core_rsp,
   input wire logic [4:0] system_config_register,
   input wire logic bus_master,
   // pins
   input wire logic [31:0] addr_out,
   input wire logic addr_oe_n,
   input wire logic [47:0] data_out,
   input wire logic [47:0] data_oe_n,
   input wire logic [3:0] bank_select_n,
   input wire logic bank_select_oe_n,
   input wire logic dram_sel_n,
   input wire logic bus_suspend_tristate,
   input wire logic ack_in
);
   // ======================================
   // expected write lanes for the held request
   logic [47:0] lane_n;
   logic [47:0] lane_d;
   always_comb begin
      case (core_req.width)
         EBLS_W32: lane_n = 48'h0000_0000_FFFF;
         EBLS_W40: lane_n = 48'h0000_0000_00FF;
         EBLS_W16: lane_n = 48'hFFFF_0000_FFFF;
         default: lane_n = 48'hFFFF_FF00_FFFF;
      endcase
      lane_d = (core_req.width == EBLS_W40) ? {core_req.wdata, 8'h00} : {core_req.wdata[31:0], 16'h0000};
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_slave_float: assert property (!bus_master [*2] |-> addr_oe_n && bank_select_oe_n)
      else $error("outputs driven while not master");
   a_suspend_float: assert property (bus_suspend_tristate [*6] |-> addr_oe_n && bank_select_oe_n && &data_oe_n)
      else $error("outputs driven while suspended");
   a_sel_decode: assert property (bank_select_n != 4'hF |-> (~bank_select_n) == (4'h1 << (addr_out >> system_config_register)))
      else $error("bank select does not match address");
   a_sel_driven: assert property (bank_select_n != 4'hF |-> !addr_oe_n && !bank_select_oe_n)
      else $error("bank selected without driving");
   a_sel_with_addr: assert property (!addr_oe_n && $changed(addr_out) |-> bank_select_n != 4'hF)
      else $error("address driven without bank select");
   a_idle_sel: assert property (core_rsp.done |-> bank_select_n == 4'hF)
      else $error("bank select active after access");
   a_cond_dry: assert property (core_req.valid && !core_req.cond |-> &data_oe_n)
      else $error("data driven for false condition");
   a_ack_hold: assert property (!ack_in [*7] |-> !core_rsp.done)
      else $error("access completed during wait");
   a_write_lanes: assert property (!(&data_oe_n) |-> data_oe_n == lane_n && (data_out & ~lane_n) == (lane_d & ~lane_n))
      else $error("write lanes wrong");
   a_dram_bank0: assert property (!dram_sel_n |-> !bank_select_n[0] || !$past(bank_select_n[0]))
      else $error("dram select outside bank zero");
endmodule

bind ebls_lane_select ebls_lane_chk ebls_lane_chk_i (.ref_clk, .rst_n, .core_req, .core_rsp, .system_config_register,
   .bus_master, .addr_out, .addr_oe_n, .data_out, .data_oe_n, .bank_select_n, .bank_select_oe_n, .dram_sel_n,
   .bus_suspend_tristate, .ack_in);

// File: ebls_mem_model.sv
`timescale 1ns/100ps
module ebls_mem_model (
   // clock and control
   input wire logic ref_clk,
   input wire logic slow,
   input wire logic host_drive,
   input wire logic [31:0] host_addr,
   // pins from the block
   input wire logic [31:0] addr_out,
   input wire logic addr_oe_n,
   input wire logic [3:0] bank_select_n,
   input wire logic [47:0] data_oe_n,
   // pins to the block
   output logic [31:0] addr_in,
   output logic [47:0] data_in,
   output logic [47:0] data_in_en,
   output logic ack_in
);
   // ======================================
   // memory answers on every lane, block must pick its own
   logic [2:0] wait_cnt;
   logic rd;
   assign rd = !addr_oe_n && (&data_oe_n);
   assign data_in = rd ? {addr_out[23:0], ~addr_out[23:0]} : ~{addr_out[23:0], ~addr_out[23:0]};
   assign data_in_en = rd ? 48'hFFFF_FFFF_FFFF : 48'h0000_0000_0000;
   assign addr_in = host_drive ? host_addr : ~host_addr;
   always_ff @(posedge ref_clk) begin
      if (addr_oe_n || bank_select_n == 4'hF) begin
         wait_cnt <= 3'h0;
      end else if (wait_cnt != 3'h7) begin
         wait_cnt <= wait_cnt + 3'h1;
      end
   end
   // slow device holds acknowledge low for seven cycles
   assign ack_in = !(slow && wait_cnt < 3'h7);
endmodule

// File: tb_ebls_lane_select.sv
`timescale 1ns/100ps
module tb_ebls_lane_select;
   import ebls_pkg::*;
   logic ref_clk, rst_n, bus_master, page_cross, bus_suspend_tristate, slow, host_drive, dram_seen;
   logic addr_oe_n, bank_select_oe_n, dram_sel_n, page_out, ack_in;
   logic [4:0] cfg;
   logic [31:0] host_addr, addr_in, addr_out, slave_addr;
   logic [47:0] data_in, data_in_en, data_out, data_oe_n;
   logic [3:0] bank_select_n, sel_seen;
   logic [39:0] rd;
   ebls_req_t core_req;
   ebls_rsp_t core_rsp;
   int miscompares, num_checks, cycles, waited;
   ebls_lane_select ebls_lane_select_i (.ref_clk, .rst_n, .core_req, .core_rsp, .system_config_register(cfg),
      .bus_master, .page_cross, .slave_addr, .addr_in, .addr_out, .addr_oe_n, .data_in, .data_in_en, .data_out,
      .data_oe_n, .bank_select_n, .bank_select_oe_n, .dram_sel_n, .page_out, .bus_suspend_tristate, .ack_in);
   ebls_mem_model ebls_mem_model_i (.ref_clk, .slow, .host_drive, .host_addr, .addr_out, .addr_oe_n, .bank_select_n,
      .data_oe_n,
      .addr_in, .data_in, .data_in_en, .ack_in);
   // ======================================
   // clock, watchdog and select monitor
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
      sel_seen <= (core_req.valid !== 1'b1) ? 4'hF : ((bank_select_n != 4'hF) ? bank_select_n : sel_seen);
      dram_seen <= (core_req.valid === 1'b1) && (dram_seen || dram_sel_n === 1'b0);
   end
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [47:0] exp_read(input ebls_width_t w, input logic [31:0] a);
      logic [47:0] p;
      p = {a[23:0], ~a[23:0]};
      case (w)
         EBLS_W32: return {16'h0000, p[47:16]};
         EBLS_W40: return {8'h00, p[47:8]};
         EBLS_W16: return {32'h0000_0000, p[31:16]};
         default: return {40'h00_0000_0000, p[23:16]};
      endcase
   endfunction
   task automatic access(input ebls_width_t w, input logic wr, input logic cnd, input logic [31:0] a);
      core_req <= '{1'b1, wr, cnd, w, a, 40'hA5_C3F0_9E17};
      waited = 0;
      do begin
         @(posedge ref_clk);
         waited++;
      end while (core_rsp.done !== 1'b1 && waited < 40);
      rd = core_rsp.rdata;
      core_req.valid <= 1'b0;
      @(posedge ref_clk);
   endtask
   // ======================================
   // scenarios
   task automatic t_lanes();
      for (int i = 0; i < 4; i++) begin
         access(ebls_width_t'(i), 1'b1, 1'b1, {6'h00, i[1:0], 24'h3C_5A81});
         check("write select", {44'h0, ~(4'h1 << i)}, {44'h0, sel_seen});
         access(ebls_width_t'(i), 1'b0, 1'b1, {6'h00, i[1:0], 24'h3C_5A81});
         check("read lanes", exp_read(ebls_width_t'(i), {6'h00, i[1:0], 24'h3C_5A81}), {8'h00, rd});
      end
      $display("test lanes done");
   endtask
   task automatic t_cond_dram();
      page_cross <= 1'b1;
      access(EBLS_W32, 1'b1, 1'b0, 32'h0012_3456);
      check("false cond select", 48'hE, {44'h0, sel_seen});
      check("dram select", 48'h1, {47'h0, dram_seen});
      page_cross <= 1'b0;
      $display("test cond done");
   endtask
   task automatic t_wait();
      slow <= 1'b1;
      cfg <= 5'h08;
      access(EBLS_W40, 1'b0, 1'b1, 32'h0000_0377);
      check("stall length", 48'h1, {47'h0, waited >= 9});
      check("stalled read", exp_read(EBLS_W40, 32'h0000_0377), {8'h00, rd});
      check("stalled select", 48'h7, {44'h0, sel_seen});
      slow <= 1'b0;
      cfg <= 5'h18;
      $display("test wait done");
   endtask
   task automatic t_float(input logic susp);
      bus_master <= susp;
      host_drive <= !susp;
      bus_suspend_tristate <= susp;
      core_req.valid <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check("float outputs", 48'h3, {46'h0, addr_oe_n, bank_select_oe_n});
      check("no done", 48'h0, {47'h0, core_rsp.done});
      if (!susp) check("slave address", {16'h0, host_addr}, {16'h0, slave_addr});
      core_req.valid <= 1'b0;
      bus_master <= 1'b1;
      host_drive <= 1'b0;
      bus_suspend_tristate <= 1'b0;
      repeat (5) @(posedge ref_clk);
      $display("test float done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      {rst_n, page_cross, bus_suspend_tristate, slow, host_drive} = 5'h00;
      bus_master = 1'b1;
      host_addr = 32'h1234_5678;
      cfg = 5'h18;
      core_req = '0;
      {miscompares, num_checks, cycles} = 96'h0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_lanes();
      t_cond_dram();
      t_wait();
      t_float(1'b0);
      t_float(1'b1);
      t_lanes();
      complete_run();
   end
endmodule
